// ---- synth_regs_pkg.sv ----
// shared constants, types and register map for the synthesizer counter and pa ramp bank
package synth_regs_pkg;

   // ==========================================================
   // widths and carrier types
   typedef logic [7:0] byte_t;
   typedef logic [7:0] addr_t;
   typedef logic [11:0] cycles_t;

   // one register port request, as driven by the host access logic
   typedef struct packed {
      addr_t addr;
      byte_t wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   // counter set presented to the synthesizer
   typedef struct packed {
      byte_t r;
      byte_t p;
      byte_t s;
   } synth_set_s;

   // ==========================================================
   // register offsets
   localparam addr_t GEN_CFG_ADDR = 8'h00;
   localparam addr_t SET1_R_ADDR = 8'h06;
   localparam addr_t SET1_P_ADDR = 8'h07;
   localparam addr_t SET1_S_ADDR = 8'h08;
   localparam addr_t SET2_R_ADDR = 8'h09;
   localparam addr_t SET2_P_ADDR = 8'h0A;
   localparam addr_t SET2_S_ADDR = 8'h0B;
   localparam addr_t AMP_RAMP_ADDR = 8'h0C;

   // ==========================================================
   // reset values and writable-bit masks
   localparam byte_t GEN_CFG_RST = 8'h00;
   localparam byte_t SET1_R_RST = 8'h77;
   localparam byte_t SET1_P_RST = 8'h64;
   localparam byte_t SET1_S_RST = 8'h32;
   localparam byte_t SET2_R_RST = 8'h74;
   localparam byte_t SET2_P_RST = 8'h62;
   localparam byte_t SET2_S_RST = 8'h32;
   localparam byte_t AMP_RAMP_RST = 8'h38;
   localparam byte_t FULL_MASK = 8'hFF;
   localparam byte_t GEN_CFG_MASK = 8'h01;
   localparam byte_t AMP_RAMP_MASK = 8'h18;
   localparam byte_t UNMAPPED_READ = 8'h00;

   // ==========================================================
   // field positions
   localparam int unsigned PROFILE_SEL_BIT = 0;
   localparam int unsigned RAMP_LSB = 3;
   localparam int unsigned RAMP_MSB = 4;
   localparam logic [1:0] RAMP_CODE_23US = 2'b11;
   localparam logic [1:0] RAMP_CODE_15US = 2'b10;
   localparam logic [1:0] RAMP_CODE_8US5 = 2'b01;
   localparam logic [1:0] RAMP_CODE_3US = 2'b00;

   // ==========================================================
   // register table, one entry per mapped register
   localparam int unsigned NUM_REGS = 8;
   localparam int unsigned IDX_GEN = 0;
   localparam int unsigned IDX_S1R = 1;
   localparam int unsigned IDX_S1P = 2;
   localparam int unsigned IDX_S1S = 3;
   localparam int unsigned IDX_S2R = 4;
   localparam int unsigned IDX_S2P = 5;
   localparam int unsigned IDX_S2S = 6;
   localparam int unsigned IDX_AMP = 7;
   localparam addr_t REG_ADDR [NUM_REGS] = '{GEN_CFG_ADDR, SET1_R_ADDR, SET1_P_ADDR,
      SET1_S_ADDR, SET2_R_ADDR, SET2_P_ADDR, SET2_S_ADDR, AMP_RAMP_ADDR};
   localparam byte_t REG_RST [NUM_REGS] = '{GEN_CFG_RST, SET1_R_RST, SET1_P_RST,
      SET1_S_RST, SET2_R_RST, SET2_P_RST, SET2_S_RST, AMP_RAMP_RST};
   localparam byte_t REG_MASK [NUM_REGS] = '{GEN_CFG_MASK, FULL_MASK, FULL_MASK,
      FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, AMP_RAMP_MASK};

   // ==========================================================
   // ramp times and their cycle counts at the system clock
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned RAMP_23US_NS = 23000;
   localparam int unsigned RAMP_15US_NS = 15000;
   localparam int unsigned RAMP_8US5_NS = 8500;
   localparam int unsigned RAMP_3US_NS = 3000;
   localparam cycles_t RAMP_23US_CYC = cycles_t'(RAMP_23US_NS / CLK_PERIOD_NS);
   localparam cycles_t RAMP_15US_CYC = cycles_t'(RAMP_15US_NS / CLK_PERIOD_NS);
   localparam cycles_t RAMP_8US5_CYC = cycles_t'(RAMP_8US5_NS / CLK_PERIOD_NS);
   localparam cycles_t RAMP_3US_CYC = cycles_t'(RAMP_3US_NS / CLK_PERIOD_NS);
   localparam cycles_t CYC_ONE = 12'h001;
   localparam cycles_t CYC_ZERO = 12'h000;

endpackage

// ---- cfg_reg_cell.sv ----
// one 8-bit configuration register with a reset value and a writable-bit mask
`timescale 1ns/1ps
module cfg_reg_cell #(
   parameter synth_regs_pkg::byte_t RST_VAL = 8'h00,
   parameter synth_regs_pkg::byte_t WMASK = 8'hFF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire synth_regs_pkg::byte_t wdata,
   output synth_regs_pkg::byte_t q,
   output synth_regs_pkg::byte_t nxt
);
   import synth_regs_pkg::*;

   // ==========================================================
   // next value: masked bits follow the write, the rest keep their reset value
   always_comb begin
      nxt = q;
      if (wr_en) begin
         nxt = (q & ~WMASK) | (wdata & WMASK);
      end
   end

   // ==========================================================
   // storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_VAL;
      end else begin
         q <= nxt;
      end
   end

endmodule // cfg_reg_cell

// ---- ramp_timer.sv ----
// down counter that times one pa ramp and flags its end
`timescale 1ns/1ps
module ramp_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire synth_regs_pkg::cycles_t load,
   output logic busy,
   output logic done
);
   import synth_regs_pkg::*;

   cycles_t cnt_r;

   // ==========================================================
   // a start while busy restarts the count; callers only start from rest
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= CYC_ZERO;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_r <= load - CYC_ONE;
            busy <= 1'b1;
         end else if (busy) begin
            if (cnt_r == CYC_ZERO) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - CYC_ONE;
            end
         end
      end
   end

endmodule // ramp_timer

// ---- synth_counter_pa_ramp_regs.sv ----
// synthesizer counter set registers, profile multiplexer and pa ramp control
// register port: one-cycle write or read strobe, read data stand the cycle after
// unmapped addresses read as zero and pulse bad_addr_r for one cycle
// at most one of the ramp status outputs is high, following the sequencer state
// pa_request and ook_mode are same-clock levels from the transmit logic
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module synth_counter_pa_ramp_regs (
   input wire logic clk,
   input wire logic nrst,
   input wire synth_regs_pkg::reg_req_s reg_req,
   input wire logic pa_request,
   input wire logic ook_mode,
   output synth_regs_pkg::byte_t rd_data_r,
   output logic bad_addr_r,
   output synth_regs_pkg::synth_set_s synth_set_r,
   output logic active_profile_r,
   output synth_regs_pkg::cycles_t ramp_cycles_r,
   output logic ramp_rise_r,
   output logic ramp_fall_r,
   output logic pa_full_r
);
   import synth_regs_pkg::*;

   // ==========================================================
   // pa ramp sequencer states
   typedef enum logic [1:0] {
      PA_OFF,
      PA_RISE,
      PA_ON,
      PA_FALL
   } pa_state_e;

   logic rst_meta_r;
   logic rst_n;
   logic [NUM_REGS-1:0] wr_en;
   byte_t reg_q [NUM_REGS];
   byte_t reg_nxt [NUM_REGS];
   logic addr_hit;
   byte_t rd_data_nxt;
   logic sel_nxt;
   synth_set_s synth_set_nxt;
   cycles_t ramp_cycles_nxt;
   pa_state_e pa_state_r;
   pa_state_e pa_state_nxt;
   logic timer_start;
   cycles_t timer_load;
   logic timer_busy;
   logic timer_done;

   // ==========================================================
   // reset release
   // assertion is immediate, release passes two flops so every register
   // leaves reset on the same edge regardless of where nrst lands
   // the cost is two extra cycles before the first register access, which
   // the host must allow for after it lets nrst go
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ==========================================================
   // register file
   // one cell per mapped register; offsets, reset values and the writable
   // masks all come from the package table, so the map lives in one place
   // a cleared mask bit pins that bit to its reset value, which is how the
   // reserved and fixed fields read back unchanged
   generate
      for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
         // address decode for writes
         assign wr_en[i] = reg_req.wr && (reg_req.addr == REG_ADDR[i]);
         cfg_reg_cell #(
            .RST_VAL(REG_RST[i]),
            .WMASK(REG_MASK[i])
         ) u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .wr_en(wr_en[i]),
            .wdata(reg_req.wdata),
            .q(reg_q[i]),
            .nxt(reg_nxt[i])
         );
      end
   endgenerate

   // the amplifier register masks its reserved bits, so they keep 001 and 000
   // even if software breaks the convention; the device does not depend on it

   // ==========================================================
   // named views of the fields
   // these are next values, so the multiplexer and the ramp decode see a
   // write on the same edge that stores it; the read path uses the stored
   // copies, so a read never returns a value that is not yet committed

   // profile select bit of the general configuration register
   logic profile_select;

   // counter fields of both sets and the ramp field
   byte_t profile_one_r_value;
   byte_t profile_one_p_value;
   byte_t profile_one_s_value;
   byte_t profile_two_r_value;
   byte_t profile_two_p_value;
   byte_t profile_two_s_value;
   logic [1:0] amp_ramp_time_field;

   // select bit
   assign profile_select = reg_nxt[IDX_GEN][PROFILE_SEL_BIT];

   // counter and ramp fields
   assign profile_one_r_value = reg_nxt[IDX_S1R];
   assign profile_one_p_value = reg_nxt[IDX_S1P];
   assign profile_one_s_value = reg_nxt[IDX_S1S];
   assign profile_two_r_value = reg_nxt[IDX_S2R];
   assign profile_two_p_value = reg_nxt[IDX_S2P];
   assign profile_two_s_value = reg_nxt[IDX_S2S];
   assign amp_ramp_time_field = reg_nxt[IDX_AMP][RAMP_MSB:RAMP_LSB];

   // ==========================================================
   // read decode
   // a read in the same cycle as a write to that register returns the old
   // contents; the master never issues both strobes together anyway
   // holes in the map belong to neighbouring blocks; here they read as zero
   // and only raise bad_addr_r, so a stray access changes nothing
   always_comb begin
      rd_data_nxt = UNMAPPED_READ;
      addr_hit = 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (reg_req.addr == REG_ADDR[i]) begin
            rd_data_nxt = reg_q[i];
            addr_hit = 1'b1;
         end
      end
   end

   // read data stand for exactly the cycle after the strobe, zero otherwise
   // zero between reads keeps a shared read bus free of stale bytes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= UNMAPPED_READ;
      end else if (reg_req.rd) begin
         rd_data_r <= rd_data_nxt;
      end else begin
         rd_data_r <= UNMAPPED_READ;
      end
   end

   // one-cycle flag for a read or write that hit no register
   // a status pulse only; nothing in the bank reacts to it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bad_addr_r <= 1'b0;
      end else begin
         bad_addr_r <= (reg_req.rd || reg_req.wr) && !addr_hit;
      end
   end

   // ==========================================================
   // profile multiplexer
   // built from the registers' next values so the synthesizer sees the new
   // set on the same edge that stores the new select bit, with no extra lag
   // both sets are always stored; only the multiplexer decides which is live
   assign sel_nxt = profile_select;

   always_comb begin
      if (sel_nxt) begin
         synth_set_nxt.r = profile_two_r_value;
         synth_set_nxt.p = profile_two_p_value;
         synth_set_nxt.s = profile_two_s_value;
      end else begin
         synth_set_nxt.r = profile_one_r_value;
         synth_set_nxt.p = profile_one_p_value;
         synth_set_nxt.s = profile_one_s_value;
      end
   end

   // registered set and select shown to the synthesizer
   // the select copy tells software which set the synthesizer is using
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         synth_set_r <= {SET1_R_RST, SET1_P_RST, SET1_S_RST};
         active_profile_r <= 1'b0;
      end else begin
         synth_set_r <= synth_set_nxt;
         active_profile_r <= sel_nxt;
      end
   end

   // ==========================================================
   // ramp time decode
   // the default arm cannot be reached with a two-bit field; it keeps the
   // decode total and falls back to the longest, gentlest ramp
   always_comb begin
      case (amp_ramp_time_field)
         RAMP_CODE_23US: ramp_cycles_nxt = RAMP_23US_CYC;
         RAMP_CODE_15US: ramp_cycles_nxt = RAMP_15US_CYC;
         RAMP_CODE_8US5: ramp_cycles_nxt = RAMP_8US5_CYC;
         RAMP_CODE_3US: ramp_cycles_nxt = RAMP_3US_CYC;
         default: ramp_cycles_nxt = RAMP_23US_CYC;
      endcase
   end

   // current setting, reset to the longest ramp
   // registering the decode keeps the timer load path starting at a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_cycles_r <= RAMP_23US_CYC;
      end else begin
         ramp_cycles_r <= ramp_cycles_nxt;
      end
   end

   // ==========================================================
   // pa ramp sequencer
   // pa_request and ook_mode come from transmit logic on this clock, so
   // they are read without synchronisers. the ramp length is taken when a
   // ramp starts; a register change mid-ramp applies to the next ramp only,
   // which avoids a truncated or stretched edge on the regulator
   // a ramp status output stays high for the loaded count plus one cycle:
   // the timer loads count minus one, flags done after count edges, and
   // the state moves on at the edge after done
   assign timer_load = ramp_cycles_r;

   // next state and timer start; one decision per edge
   always_comb begin
      pa_state_nxt = pa_state_r;
      timer_start = 1'b0;
      case (pa_state_r)
         PA_OFF: begin
            if (pa_request && ook_mode) begin
               pa_state_nxt = PA_RISE;
               timer_start = 1'b1;
            end else if (pa_request) begin
               pa_state_nxt = PA_ON;
            end
         end
         PA_RISE: begin
            // a request dropped mid-rise still finishes the rise, then falls
            if (timer_done) begin
               if (pa_request) begin
                  pa_state_nxt = PA_ON;
               end else begin
                  pa_state_nxt = PA_FALL;
                  timer_start = 1'b1;
               end
            end
         end
         PA_ON: begin
            if (!pa_request && ook_mode) begin
               pa_state_nxt = PA_FALL;
               timer_start = 1'b1;
            end else if (!pa_request) begin
               pa_state_nxt = PA_OFF;
            end
         end
         PA_FALL: begin
            if (timer_done) begin
               pa_state_nxt = PA_OFF;
            end
         end
         default: begin
            pa_state_nxt = PA_OFF;
         end
      endcase
   end

   // sequencer state
   // the state register alone; outputs and timer start come from the next state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pa_state_r <= PA_OFF;
      end else begin
         pa_state_r <= pa_state_nxt;
      end
   end

   // ramp length counter
   // shared by rise and fall, which never overlap in the sequencer
   ramp_timer u_ramp_timer (
      .clk(clk),
      .rst_n(rst_n),
      .start(timer_start),
      .load(timer_load),
      .busy(timer_busy),
      .done(timer_done)
   );

   // ==========================================================
   // ramp status outputs, registered from the next state so each one
   // lines up with the state register instead of trailing it by a cycle

   // rising ramp in progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_rise_r <= 1'b0;
      end else begin
         ramp_rise_r <= (pa_state_nxt == PA_RISE);
      end
   end

   // falling ramp in progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_fall_r <= 1'b0;
      end else begin
         ramp_fall_r <= (pa_state_nxt == PA_FALL);
      end
   end

   // amplifier fully on, with or without a ramp behind it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pa_full_r <= 1'b0;
      end else begin
         pa_full_r <= (pa_state_nxt == PA_ON);
      end
   end

   // timer_busy is only an internal view; the state machine keys on done
   // busy stays wired so the timer keeps one port list for every user
   logic unused_busy;
   assign unused_busy = timer_busy;

endmodule // synth_counter_pa_ramp_regs

// ---- synth_counter_pa_ramp_regs_props.sv ----
// concurrent checks on the counter set and pa ramp register bank ports
`timescale 1ns/1ps
module synth_counter_pa_ramp_regs_props (
   input wire logic clk,
   input wire logic nrst,
   input wire synth_regs_pkg::reg_req_s reg_req,
   input wire logic pa_request,
   input wire logic ook_mode,
   input wire synth_regs_pkg::byte_t rd_data_r,
   input wire logic bad_addr_r,
   input wire synth_regs_pkg::synth_set_s synth_set_r,
   input wire logic active_profile_r,
   input wire synth_regs_pkg::cycles_t ramp_cycles_r,
   input wire logic ramp_rise_r,
   input wire logic ramp_fall_r,
   input wire logic pa_full_r
);
   import synth_regs_pkg::*;
   byte_t wd_q;
   cycles_t cyc_q, code_cyc;
   logic rd_q, bad_q, unmapped, set1_wr, wr;
   addr_t a;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // =====
   // helpers: one-cycle copies of the request, so checks need no $past of members
   assign wr = reg_req.wr;
   assign a = reg_req.addr;
   assign unmapped = (reg_req.rd | wr) && !(a inside {8'h00, [8'h06:8'h0C]});
   assign set1_wr = wr && (a inside {8'h00, [8'h06:8'h08]});
   assign code_cyc = reg_req.wdata[4] ? (reg_req.wdata[3] ? 12'h08FC : 12'h05DC)
      : (reg_req.wdata[3] ? 12'h0352 : 12'h012C);
   always_ff @(posedge clk) begin
      wd_q <= reg_req.wdata;
      rd_q <= reg_req.rd;
      bad_q <= unmapped;
      cyc_q <= code_cyc;
   end
   // =====
   // register, multiplexer and ramp sequencer relations
   AST_S1: assert property (wr && a == 8'h08 && !active_profile_r |=> synth_set_r.s == wd_q)
      else $error("set one s not applied");
   AST_R2: assert property (wr && a == 8'h09 && active_profile_r |=> synth_set_r.r == wd_q)
      else $error("set two r not applied");
   AST_P2: assert property (wr && a == 8'h0A && active_profile_r |=> synth_set_r.p == wd_q)
      else $error("set two p not applied");
   AST_S2: assert property (wr && a == 8'h0B && active_profile_r |=> synth_set_r.s == wd_q)
      else $error("set two s not applied");
   AST_SEL: assert property (wr && a == 8'h00 |=> active_profile_r == wd_q[0])
      else $error("profile select not taken");
   AST_HOLD: assert property (!active_profile_r && !set1_wr |=> $stable(synth_set_r))
      else $error("set one output moved");
   AST_RAMP: assert property (wr && a == 8'h0C |=> ramp_cycles_r == cyc_q)
      else $error("ramp length wrong");
   AST_BAD: assert property (bad_addr_r == bad_q)
      else $error("bad address flag wrong");
   AST_RD_IDLE: assert property (!rd_q |-> rd_data_r == 8'h00)
      else $error("read data outside its cycle");
   AST_RISE: assert property (ook_mode && pa_request && !ramp_rise_r && !ramp_fall_r && !pa_full_r
      |=> ramp_rise_r)
      else $error("ramp did not start");
   AST_RISE_MIN: assert property ($rose(ramp_rise_r) |-> ramp_rise_r [*8])
      else $error("ramp too short");
   AST_ONE: assert property ($onehot0({ramp_rise_r, ramp_fall_r, pa_full_r}))
      else $error("sequencer states overlap");
   // =====
   // main scenarios reached
   cover property ($fell(ramp_rise_r) && pa_full_r);
   cover property (bad_addr_r);
   cover property (active_profile_r && wr && a == 8'h0B);
endmodule // synth_counter_pa_ramp_regs_props

// ---- reg_host.sv ----
// host master model on the register port
`timescale 1ns/1ps
module reg_host (
   input wire logic clk,
   input wire synth_regs_pkg::byte_t rd_data,
   output synth_regs_pkg::reg_req_s req
);
   import synth_regs_pkg::*;
   // =====
   // bus cycles; released address and data show the inverse, not the last value
   initial req = '0;
   task automatic wr(input addr_t a, input byte_t d);
      @(posedge clk);
      if (a == AMP_RAMP_ADDR) d = {3'b001, d[4:3], 3'b000};
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      #1;
   endtask
   task automatic rd(input addr_t a, output byte_t d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      #1;
      d = rd_data;
   endtask
endmodule // reg_host

// ---- synth_counter_pa_ramp_regs_bench.sv ----
// self-checking bench for the counter set and pa ramp register bank
`timescale 1ns/1ps
module synth_counter_pa_ramp_regs_bench;
   import synth_regs_pkg::*;
   logic clk, nrst, pa_request, ook_mode, bad_addr_r, active_profile_r;
   logic ramp_rise_r, ramp_fall_r, pa_full_r, sel;
   reg_req_s reg_req;
   byte_t rd_data_r, d;
   synth_set_s synth_set_r;
   cycles_t ramp_cycles_r;
   int bad_count = 0, checks_done = 0, cyc = 0, n, j;
   logic [31:0] seed = 32'h0001_54CC;
   logic [1:0] code;
   byte_t m [6] = '{8'h77, 8'h64, 8'h32, 8'h74, 8'h62, 8'h32};
   synth_counter_pa_ramp_regs uut (.clk(clk), .nrst(nrst), .reg_req(reg_req),
      .pa_request(pa_request), .ook_mode(ook_mode), .rd_data_r(rd_data_r),
      .bad_addr_r(bad_addr_r), .synth_set_r(synth_set_r), .active_profile_r(active_profile_r),
      .ramp_cycles_r(ramp_cycles_r), .ramp_rise_r(ramp_rise_r), .ramp_fall_r(ramp_fall_r),
      .pa_full_r(pa_full_r));
   reg_host host (.clk(clk), .rd_data(rd_data_r), .req(reg_req));
   // =====
   // expectations, comparison and verdict
   function automatic cycles_t ramp_len(input logic [1:0] c);
      case (c)
         2'b11: return 12'h08FC;
         2'b10: return 12'h05DC;
         2'b01: return 12'h0352;
         default: return 12'h012C;
      endcase
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // counts a ramp level; bounded so a stuck sequencer cannot hang the run
   task automatic ramp_count(input logic rise, output int cnt);
      cnt = 0;
      while ((rise ? ramp_rise_r : ramp_fall_r) === 1'b1 && cnt < 5000) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask
   // =====
   // clock and hang limit
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         check("timeout", 24'h00_0001, 24'h00_0000);
         print_verdict();
      end
   end
   // =====
   // main sequence
   initial begin
      nrst = 1'b0;
      pa_request = 1'b0;
      ook_mode = 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("set", synth_set_r, 24'h77_6432);
      check("ramp", ramp_cycles_r, ramp_len(2'b11));
      for (int i = 0; i < 6; i++) begin
         host.rd(addr_t'(8'h06 + i), d);
         check("reset", d, m[i]);
      end
      host.rd(8'h0C, d);
      check("amp reset", d, 8'h38);
      check("bad addr", bad_addr_r, 1'b0);
      // unmapped places: writes lost, reads empty
      host.wr(8'h01, 8'hA5);
      check("bad addr", bad_addr_r, 1'b1);
      host.rd(8'h01, d);
      check("unmapped", d, 8'h00);
      host.rd(8'h0D, d);
      check("unmapped", d, 8'h00);
      check("bad addr", bad_addr_r, 1'b1);
      // random counter traffic with the profile select flipping under it
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         j = seed[2:0] % 6;
         m[j] = seed[15:8];
         sel = seed[16];
         host.wr(addr_t'(8'h06 + j), m[j]);
         host.wr(8'h00, seed[23:16]);
         host.rd(addr_t'(8'h06 + j), d);
         check("rw", d, m[j]);
         check("sel", active_profile_r, sel);
         check("mux", synth_set_r, sel ? {m[3], m[4], m[5]} : {m[0], m[1], m[2]});
      end
      host.rd(8'h00, d);
      check("gen cfg", d, {7'h00, sel});
      // every ramp code, ending on the shortest
      for (int c = 0; c < 4; c++) begin
         seed = lfsr(seed);
         code = 2'(3 - c);
         host.wr(8'h0C, {seed[7:5], code, seed[2:0]});
         check("ramp", ramp_cycles_r, ramp_len(code));
         host.rd(8'h0C, d);
         check("amp", d, {3'b001, code, 3'b000});
      end
      // ook ramp up, hold, ramp down
      @(posedge clk);
      ook_mode <= 1'b1;
      pa_request <= 1'b1;
      @(posedge clk);
      #1;
      ramp_count(1'b1, n);
      check("rise len", 24'(n), 24'(ramp_len(2'b00)) + 24'h00_0001);
      check("full", pa_full_r, 1'b1);
      @(posedge clk);
      pa_request <= 1'b0;
      @(posedge clk);
      #1;
      ramp_count(1'b0, n);
      check("fall len", 24'(n), 24'(ramp_len(2'b00)) + 24'h00_0001);
      // without ook the amplifier follows the request with no ramp
      @(posedge clk);
      ook_mode <= 1'b0;
      pa_request <= 1'b1;
      @(posedge clk);
      #1;
      check("direct on", pa_full_r, 1'b1);
      @(posedge clk);
      pa_request <= 1'b0;
      @(posedge clk);
      #1;
      check("direct off", pa_full_r, 1'b0);
      print_verdict();
   end
endmodule // synth_counter_pa_ramp_regs_bench
bind synth_counter_pa_ramp_regs synth_counter_pa_ramp_regs_props chk (.clk(clk), .nrst(nrst),
   .reg_req(reg_req), .pa_request(pa_request), .ook_mode(ook_mode), .rd_data_r(rd_data_r),
   .bad_addr_r(bad_addr_r), .synth_set_r(synth_set_r), .active_profile_r(active_profile_r),
   .ramp_cycles_r(ramp_cycles_r), .ramp_rise_r(ramp_rise_r), .ramp_fall_r(ramp_fall_r),
   .pa_full_r(pa_full_r));
